// ---- rtl/ecm_consts.vh ----
// Constants for the effect chain routing mixer: register offsets, field positions,
// reset values and arithmetic scaling.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`ifndef ECM_CONSTS_VH
`define ECM_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ECM_OFF_CTRL 8'h00
`define ECM_OFF_SEND_B 8'h04
`define ECM_OFF_AB_BLEND 8'h08
`define ECM_OFF_C_BLEND 8'h0c
`define ECM_OFF_RET_A_L 8'h10
`define ECM_OFF_RET_A_R 8'h14
`define ECM_OFF_RET_B_L 8'h18
`define ECM_OFF_RET_B_R 8'h1c
`define ECM_OFF_RET_C_L 8'h20
`define ECM_OFF_RET_C_R 8'h24
`define ECM_OFF_WET_DRY 8'h28
`define ECM_OFF_OUT_GAIN 8'h2c
`define ECM_OFF_STATUS 8'h30

// ****************************************************************
// Register indices and count
// ****************************************************************
`define ECM_IDX_CTRL 4'h0
`define ECM_IDX_SEND_B 4'h1
`define ECM_IDX_AB_BLEND 4'h2
`define ECM_IDX_C_BLEND 4'h3
`define ECM_IDX_RET_A_L 4'h4
`define ECM_IDX_RET_A_R 4'h5
`define ECM_IDX_RET_B_L 4'h6
`define ECM_IDX_RET_B_R 4'h7
`define ECM_IDX_RET_C_L 4'h8
`define ECM_IDX_RET_C_R 4'h9
`define ECM_IDX_WET_DRY 4'ha
`define ECM_IDX_OUT_GAIN 4'hb
`define ECM_IDX_STATUS 4'hc
`define ECM_NUM_RW 4'hc

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ECM_CTRL_THREE 0
`define ECM_CTRL_GAIN_ON 1
`define ECM_RST_CTRL 16'h0002
`define ECM_RST_ZERO 16'h0000
`define ECM_RST_FULL 16'h0064

// ****************************************************************
// Arithmetic
// ****************************************************************
`define ECM_PCT_FULL 16'sh0064
`define ECM_PCT_NEG 16'shff9c
`define ECM_GAIN_MIN 16'shfcea
`define ECM_GAIN_MAX 16'sh00f0
`define ECM_GAIN_BIAS 16'sh0348
`define ECM_GAIN_STEP 11'h03c
`define ECM_MANT_ONE 13'h1000
`define ECM_MANT_SLOPE 13'h0044
`define ECM_GAIN_SHIFT 26
`define ECM_RESP_OKAY 2'h0
`define ECM_RESP_SLVERR 2'h2

`endif

// ---- rtl/ecm_mixer.v ----
// Routing and mixing datapath for a chain of two or three effects, with an
// AXI4-Lite register file and a two-entry output buffer.
// Assumes returns and dry samples arrive together from logic on aclk.
`timescale 1ns/1ps
`include "ecm_consts.vh"

// Function
// - Two effects: send to B blends effect A output with dry input.
// - Two effects: send-to-B setting 0..100; 0 gives dry, 100 gives A.
// - Two effects: wet is A and B, each scaled -100..100, negative inverts.
// - Wet/dry setting -100..100 balances wet against dry; negative inverts wet.
// - Output gain is off or -79.0 to 24.0 dB.
// - Output gain scales the combined wet and dry signal.
// - Three effects: A feeds B and C sends, B feeds C send.
// - Three effects: send to B blends A with dry, setting -100..100.
// - Send to C blends A with B, then that sum with dry.
// - Negative blend setting inverts the operand taken fully at 100.
// - A/B blend gives only B at 0 and only A at 100.
// - C blend gives only dry at 0 and only A/B sum at 100.
// - Three effects: wet sums A, B, C with separate left and right levels.
module ecm_mixer #(
	parameter DW = 24
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Sample input: dry pair and effect returns
	input wire in_valid,
	output reg in_ready,
	input wire [DW-1:0] dry_l,
	input wire [DW-1:0] dry_r,
	input wire [DW-1:0] ret_a_l,
	input wire [DW-1:0] ret_a_r,
	input wire [DW-1:0] ret_b_l,
	input wire [DW-1:0] ret_b_r,
	input wire [DW-1:0] ret_c_l,
	input wire [DW-1:0] ret_c_r,
	// Sample output: effect sends and final mix
	output reg out_valid,
	input wire out_ready,
	output wire [DW-1:0] send_b_l,
	output wire [DW-1:0] send_b_r,
	output wire [DW-1:0] send_c_l,
	output wire [DW-1:0] send_c_r,
	output wire [DW-1:0] out_l,
	output wire [DW-1:0] out_r
);

	localparam XW = DW + 2;
	localparam AW = XW + 17;
	localparam GW = XW + 33;
	localparam PW = 6 * DW;

	// ****************************************************************
	// Arithmetic helpers
	// ****************************************************************
	function signed [15:0] clampp;
		input signed [15:0] p;
		begin
			if (p > `ECM_PCT_FULL) begin
				clampp = `ECM_PCT_FULL;
			end else if (p < `ECM_PCT_NEG) begin
				clampp = `ECM_PCT_NEG;
			end else begin
				clampp = p;
			end
		end
	endfunction

	function signed [XW-1:0] ext;
		input [DW-1:0] x;
		begin
			ext = {{2{x[DW-1]}}, x};
		end
	endfunction

	// Crossfade: the left operand carries p and flips with it, the right one
	// carries what is left of full scale.
	function signed [XW-1:0] blend;
		input signed [XW-1:0] l;
		input signed [XW-1:0] r;
		input signed [15:0] p;
		reg signed [15:0] pc;
		reg signed [15:0] rw;
		reg signed [AW-1:0] acc;
		begin
			pc = clampp(p);
			rw = `ECM_PCT_FULL - ((pc < 16'sh0000) ? -pc : pc);
			acc = l * pc + r * rw;
			acc = acc / `ECM_PCT_FULL;
			blend = acc[XW-1:0];
		end
	endfunction

	function signed [XW-1:0] level;
		input signed [XW-1:0] x;
		input signed [15:0] p;
		reg signed [AW-1:0] acc;
		begin
			acc = x * clampp(p);
			acc = acc / `ECM_PCT_FULL;
			level = acc[XW-1:0];
		end
	endfunction

	function [DW-1:0] satx;
		input signed [XW-1:0] x;
		begin
			if ((&x[XW-1:DW-1]) | ~(|x[XW-1:DW-1])) begin
				satx = x[DW-1:0];
			end else begin
				satx = {x[XW-1], {(DW-1){~x[XW-1]}}};
			end
		end
	endfunction

	function [DW-1:0] satg;
		input signed [GW-1:0] x;
		begin
			if ((&x[GW-1:DW-1]) | ~(|x[GW-1:DW-1])) begin
				satg = x[DW-1:0];
			end else begin
				satg = {x[GW-1], {(DW-1){~x[GW-1]}}};
			end
		end
	endfunction

	// Gain in tenths of a dB to a linear factor, unity at 2^26. Roughly 6 dB
	// per octave with a linear mantissa; good to a few tenths of a dB.
	function signed [32:0] gain_lin;
		input signed [15:0] t;
		reg signed [15:0] tc;
		reg [10:0] n;
		reg [10:0] f;
		reg [10:0] e;
		reg [12:0] m;
		begin
			tc = t;
			if (tc < `ECM_GAIN_MIN) begin
				tc = `ECM_GAIN_MIN;
			end
			if (tc > `ECM_GAIN_MAX) begin
				tc = `ECM_GAIN_MAX;
			end
			tc = tc + `ECM_GAIN_BIAS;
			n = tc[10:0];
			e = n / `ECM_GAIN_STEP;
			f = n % `ECM_GAIN_STEP;
			m = `ECM_MANT_ONE + f[5:0] * `ECM_MANT_SLOPE;
			gain_lin = {20'h00000, m} << e[4:0];
		end
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	reg [15:0] cfg_reg [0:11];
	reg [15:0] sample_cnt_reg;
	reg [1:0] fill_reg;
	reg [7:0] aw_addr_reg;
	reg aw_full_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg w_full_reg;
	wire [3:0] w_idx = aw_addr_reg[5:2];
	wire [3:0] r_idx = s_axi_araddr[5:2];
	wire w_hit = (aw_addr_reg[7:6] == 2'h0) && (w_idx < `ECM_NUM_RW);
	wire r_hit = (s_axi_araddr[7:6] == 2'h0) && (r_idx <= `ECM_IDX_STATUS);
	integer i;

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < `ECM_NUM_RW; i = i + 1) begin
				cfg_reg[i] <= `ECM_RST_ZERO;
			end
			cfg_reg[`ECM_IDX_CTRL] <= `ECM_RST_CTRL;
			cfg_reg[`ECM_IDX_RET_A_L] <= `ECM_RST_FULL;
			cfg_reg[`ECM_IDX_RET_A_R] <= `ECM_RST_FULL;
			cfg_reg[`ECM_IDX_RET_B_L] <= `ECM_RST_FULL;
			cfg_reg[`ECM_IDX_RET_B_R] <= `ECM_RST_FULL;
			cfg_reg[`ECM_IDX_WET_DRY] <= `ECM_RST_FULL;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ECM_RESP_OKAY;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_hit ? `ECM_RESP_OKAY : `ECM_RESP_SLVERR;
				if (w_hit && w_strb_reg[0]) begin
					cfg_reg[w_idx][7:0] <= w_data_reg[7:0];
				end
				if (w_hit && w_strb_reg[1]) begin
					cfg_reg[w_idx][15:8] <= w_data_reg[15:8];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ECM_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				if (!r_hit) begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `ECM_RESP_SLVERR;
				end else if (r_idx == `ECM_IDX_STATUS) begin
					s_axi_rdata <= {14'h0000, fill_reg, sample_cnt_reg};
					s_axi_rresp <= `ECM_RESP_OKAY;
				end else if (r_idx == `ECM_IDX_CTRL) begin
					s_axi_rdata <= {16'h0000, cfg_reg[r_idx]};
					s_axi_rresp <= `ECM_RESP_OKAY;
				end else begin
					s_axi_rdata <= {{16{cfg_reg[r_idx][15]}}, cfg_reg[r_idx]};
					s_axi_rresp <= `ECM_RESP_OKAY;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Routing and mixing datapath
	// ****************************************************************
	wire three = cfg_reg[`ECM_IDX_CTRL][`ECM_CTRL_THREE];
	wire gain_on = cfg_reg[`ECM_IDX_CTRL][`ECM_CTRL_GAIN_ON];
	wire signed [15:0] p_send_raw = cfg_reg[`ECM_IDX_SEND_B];
	// Two effects allow no inversion of A on the B send.
	wire signed [15:0] p_send = (!three && p_send_raw < 16'sh0000) ? 16'sh0000 : p_send_raw;
	wire signed [15:0] p_ab = cfg_reg[`ECM_IDX_AB_BLEND];
	wire signed [15:0] p_c = cfg_reg[`ECM_IDX_C_BLEND];
	wire signed [15:0] p_wd = cfg_reg[`ECM_IDX_WET_DRY];
	wire signed [15:0] lv_a_l = cfg_reg[`ECM_IDX_RET_A_L];
	wire signed [15:0] lv_b_l = cfg_reg[`ECM_IDX_RET_B_L];
	wire signed [15:0] lv_c_l = cfg_reg[`ECM_IDX_RET_C_L];
	// Two effects use one level per effect for both channels.
	wire signed [15:0] lv_a_r = three ? cfg_reg[`ECM_IDX_RET_A_R] : lv_a_l;
	wire signed [15:0] lv_b_r = three ? cfg_reg[`ECM_IDX_RET_B_R] : lv_b_l;
	wire signed [32:0] g_lin = gain_lin(cfg_reg[`ECM_IDX_OUT_GAIN]);

	reg signed [XW-1:0] sb_l, sb_r, st_l, st_r, sc_l, sc_r;
	reg signed [XW-1:0] wet_l, wet_r, mx_l, mx_r;
	reg signed [GW-1:0] go_l, go_r;
	reg [PW-1:0] result;

	// Left and right are formed side by side from the same sample set.
	always @* begin
		sb_l = blend(ext(ret_a_l), ext(dry_l), p_send);
		sb_r = blend(ext(ret_a_r), ext(dry_r), p_send);
		st_l = blend(ext(ret_a_l), ext(ret_b_l), p_ab);
		st_r = blend(ext(ret_a_r), ext(ret_b_r), p_ab);
		sc_l = three ? blend(st_l, ext(dry_l), p_c) : {XW{1'b0}};
		sc_r = three ? blend(st_r, ext(dry_r), p_c) : {XW{1'b0}};
		wet_l = level(ext(ret_a_l), lv_a_l) + level(ext(ret_b_l), lv_b_l);
		wet_r = level(ext(ret_a_r), lv_a_r) + level(ext(ret_b_r), lv_b_r);
		if (three) begin
			wet_l = wet_l + level(ext(ret_c_l), lv_c_l);
			wet_r = wet_r + level(ext(ret_c_r), cfg_reg[`ECM_IDX_RET_C_R]);
		end
		mx_l = blend(wet_l, ext(dry_l), p_wd);
		mx_r = blend(wet_r, ext(dry_r), p_wd);
		go_l = gain_on ? (mx_l * g_lin) >>> `ECM_GAIN_SHIFT : $signed({GW{1'b0}});
		go_r = gain_on ? (mx_r * g_lin) >>> `ECM_GAIN_SHIFT : $signed({GW{1'b0}});
		result = {satx(sb_l), satx(sb_r), satx(sc_l), satx(sc_r), satg(go_l), satg(go_r)};
	end

	// ****************************************************************
	// Two-entry output buffer
	// ****************************************************************
	reg [PW-1:0] head_reg;
	reg [PW-1:0] tail_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	reg [1:0] fill_next;

	always @* begin
		fill_next = fill_reg;
		if (push && !pop) begin
			fill_next = fill_reg + 2'h1;
		end else if (pop && !push) begin
			fill_next = fill_reg - 2'h1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			head_reg <= {PW{1'b0}};
			tail_reg <= {PW{1'b0}};
			fill_reg <= 2'h0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			sample_cnt_reg <= 16'h0000;
		end else begin
			fill_reg <= fill_next;
			in_ready <= (fill_next != 2'h2);
			out_valid <= (fill_next != 2'h0);
			if (push) begin
				sample_cnt_reg <= sample_cnt_reg + 16'h0001;
			end
			if (fill_reg == 2'h2 && pop) begin
				head_reg <= tail_reg;
			end else if (push && (fill_reg == 2'h0 || pop)) begin
				head_reg <= result;
			end else if (push) begin
				tail_reg <= result;
			end
		end
	end

	assign send_b_l = head_reg[6*DW-1:5*DW];
	assign send_b_r = head_reg[5*DW-1:4*DW];
	assign send_c_l = head_reg[4*DW-1:3*DW];
	assign send_c_r = head_reg[3*DW-1:2*DW];
	assign out_l = head_reg[2*DW-1:DW];
	assign out_r = head_reg[DW-1:0];

endmodule // ecm_mixer

// ---- dv/ecm_mixer_props.sv ----
// Concurrent checks on the mixer's register bus and sample stream ports.
// Assumes it is bound onto ecm_mixer and sees only that module's ports.
`timescale 1ns/1ps
module ecm_mixer_props #(
	parameter DW = 24
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Sample stream
	input wire in_valid,
	input wire in_ready,
	input wire out_valid,
	input wire out_ready,
	input wire [DW-1:0] send_b_l,
	input wire [DW-1:0] out_l
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response not on time");
	AST_AW_BACK: assert property (s_axi_bvalid && s_axi_bready
		|=> s_axi_awready && s_axi_wready && !s_axi_bvalid) else $error("write side not freed");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not on time");
	AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h34
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	AST_AR_BACK: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
		else $error("read side not freed");
	AST_OUT_AFTER_IN: assert property (in_valid && in_ready |=> out_valid)
		else $error("output not raised after take");
	AST_OUT_HOLD: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_l) && $stable(send_b_l)) else $error("stalled output moved");
	AST_FULL: assert property (out_valid && !out_ready && in_valid && in_ready
		|=> !in_ready) else $error("buffer took a third set");
	AST_READY_BACK: assert property (!in_ready && out_valid && out_ready |=> in_ready)
		else $error("room not reported after drain");
endmodule // ecm_mixer_props

bind ecm_mixer ecm_mixer_props #(.DW(DW)) ecm_mixer_props_inst (.*);

// ---- dv/ecm_fx_model.sv ----
// Far-side model of effect blocks A, B and C and of the output's consumer.
// Assumes the bench sets each effect's output level and may stall the consumer.
`timescale 1ns/1ps
module ecm_fx_model #(
	parameter DW = 24
) (
	// Bench control
	stall,
	fa,
	fb,
	fc,
	// Effect returns and output acceptance
	ret_a_l,
	ret_a_r,
	ret_b_l,
	ret_b_r,
	ret_c_l,
	ret_c_r,
	out_ready
);
	input wire stall;
	input wire [DW-1:0] fa, fb, fc;
	output wire [DW-1:0] ret_a_l, ret_a_r, ret_b_l, ret_b_r, ret_c_l, ret_c_r;
	output wire out_ready;
	assign ret_a_l = fa;
	assign ret_a_r = fa;
	assign ret_b_l = fb;
	assign ret_b_r = fb;
	assign ret_c_l = fc;
	assign ret_c_r = fc;
	// A slow consumer refuses output sets while stalled.
	assign out_ready = !stall;
endmodule // ecm_fx_model

// ---- dv/tb.sv ----
// Self-checking bench for the effect chain routing mixer.
// Assumes the design, its checker and the effect model compile alongside.
`timescale 1ns/1ps
module tb;
	localparam DW = 24;
	reg aclk = 0, aresetn = 0, in_valid = 0, stall = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0, rd_data;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [1:0] resp;
	reg [DW-1:0] dry_l = 0, fa = 24'h00012c, fb = 24'hffff38, fc = 24'h000032;
	wire [DW-1:0] dry_r = dry_l;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire in_ready, out_valid, out_ready;
	wire [DW-1:0] ret_a_l, ret_a_r, ret_b_l, ret_b_r, ret_c_l, ret_c_r;
	wire [DW-1:0] send_b_l, send_b_r, send_c_l, send_c_r, out_l, out_r;
	integer num_errors = 0, n_checks = 0, cyc = 0, i;
	ecm_mixer ecm_mixer_inst (.*);
	ecm_fx_model ecm_fx_model_inst (.*);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// ****************************************************************
	// Bus and stream drivers
	// ****************************************************************
	task wr(input [7:0] a, input [15:0] d);
		reg ad, wd;
		ad = 0;
		wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		rd(a);
		check("rdata", rd_data, e);
	endtask
	// Sends one sample set and compares the set that comes back.
	task sm(input [DW-1:0] d, input integer eb, ec, el, er);
		dry_l <= d;
		in_valid <= 1'b1;
		do @(posedge aclk); while (!in_ready);
		in_valid <= 1'b0;
		do @(posedge aclk); while (!(out_valid && out_ready));
		check("send_b", $signed(send_b_l), eb);
		check("send_b_r", $signed(send_b_r), eb);
		check("send_c", $signed(send_c_l), ec);
		check("send_c_r", $signed(send_c_r), ec);
		check("out_l", $signed(out_l), el);
		check("out_r", $signed(out_r), er);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_regs;
		rchk(8'h00, 32'h2);
		rchk(8'h10, 32'h64);
		rchk(8'h24, 32'h0);
		rchk(8'h28, 32'h64);
		rchk(8'h2c, 32'h0);
		rchk(8'h30, 32'h0);
		rd(8'h34);
		check("rresp", resp, 32'h2);
		check("rdata", rd_data, 32'h0);
		wr(8'h30, 16'h0001);
		check("bresp", resp, 32'h2);
	endtask
	task t_two;
		sm(1000, 1000, 0, 100, 100);
		wr(8'h04, 16'h0064);
		sm(1000, 300, 0, 100, 100);
		wr(8'h04, 16'h0028);
		sm(1000, 720, 0, 100, 100);
		wr(8'h10, 16'hff9c);
		rchk(8'h10, 32'hffffff9c);
		sm(1000, 720, 0, -500, -500);
		wr(8'h28, 16'hff9c);
		sm(1000, 720, 0, 500, 500);
		wr(8'h28, 16'h0032);
		sm(1000, 720, 0, 250, 250);
		wr(8'h2c, 16'h003c);
		sm(1000, 720, 0, 500, 500);
		wr(8'h2c, 16'h012c);
		sm(1000, 720, 0, 4000, 4000);
		wr(8'h2c, 16'h0000);
		wr(8'h00, 16'h0000);
		sm(1000, 720, 0, 0, 0);
	endtask
	task t_three;
		wr(8'h00, 16'h0003);
		wr(8'h28, 16'h0064);
		wr(8'h04, 16'hff9c);
		wr(8'h0c, 16'h0064);
		sm(1000, -300, -200, -500, 100);
		wr(8'h08, 16'h0064);
		sm(1000, -300, 300, -500, 100);
		wr(8'h08, 16'hff9c);
		sm(1000, -300, -300, -500, 100);
		wr(8'h04, 16'h0032);
		wr(8'h08, 16'h0032);
		wr(8'h0c, 16'h0032);
		sm(1000, 650, 525, -500, 100);
		wr(8'h0c, 16'hffce);
		sm(1000, 650, 475, -500, 100);
		wr(8'h0c, 16'h0000);
		wr(8'h24, 16'h0064);
		sm(1000, 650, 1000, -500, 150);
	endtask
	task t_buf;
		stall <= 1'b1;
		dry_l <= 24'h00000a;
		in_valid <= 1'b1;
		do @(posedge aclk); while (!in_ready);
		dry_l <= 24'h000014;
		do @(posedge aclk); while (!in_ready);
		dry_l <= 24'h00001e;
		repeat (3) @(posedge aclk);
		check("in_ready", in_ready, 32'h0);
		stall <= 1'b0;
		for (i = 1; i <= 3; i = i + 1) begin
			do begin
				@(posedge aclk);
				if (in_ready)
					in_valid <= 1'b0;
			end while (!(out_valid && out_ready));
			check("send_c", $signed(send_c_l), 10 * i);
		end
		rchk(8'h30, 32'h12);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_two;
		t_three;
		t_buf;
		conclude;
	end
endmodule // tb
